/* pcs_pkg.sv */
// Purpose: Shared constants and carriers for the program counter and return stack block
// Assumes: AHB-Lite register access with 32-bit data, one aligned word per register
// Notes: All control ports run on the instruction clock hclk
package pcs_pkg;
    // Address widths and stack depth
    localparam int PCS_PC_W = 13;
    localparam int PCS_PAGE_W = 11;
    localparam int PCS_LATCH_W = 5;
    localparam int PCS_DEPTH = 8;
    localparam int PCS_SP_W = 3;
    localparam int PCS_FILE_W = 9;

    // Register byte offsets
    localparam logic [7:0] PCS_OFF_LOW_BYTE = 8'h00;
    localparam logic [7:0] PCS_OFF_HIGH_LATCH = 8'h04;
    localparam logic [7:0] PCS_OFF_POINTER = 8'h08;

    // Reset values and interrupt vector
    localparam logic [12:0] PCS_PC_RST = 13'h0000;
    localparam logic [4:0] PCS_LATCH_RST = 5'h00;
    localparam logic [7:0] PCS_POINTER_RST = 8'h00;
    localparam logic [12:0] PCS_IRQ_VECTOR = 13'h0004;

    // Fields of the high latch
    localparam int PCS_PAGE_BIT = 3;

    // Pointer value that addresses the indirect data port itself
    localparam logic [7:0] PCS_INDIRECT_SELF = 8'h00;

    // AHB encodings
    localparam logic [1:0] PCS_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] PCS_HSIZE_WORD = 3'h2;

    // One instruction's worth of sequencer commands
    typedef struct packed {
        logic fetch;
        logic call;
        logic jump;
        logic ret;
        logic irq;
        logic [10:0] target;
    } pcs_cmd_t;

    // Indirect data port request from the instruction decoder
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } pcs_ind_req_t;

    function automatic logic [12:0] pcs_page_target(input logic [4:0] latch,
                                                    input logic [10:0] target);
        pcs_page_target = {latch[4:3], target};
    endfunction : pcs_page_target
endpackage : pcs_pkg

/* pcs_stack_mem.sv */
// Purpose: Return stack storage, one write port and one registered read port
// Assumes: Read address is presented one cycle before the data is needed
// Notes: A write to the address being read is forwarded to the read register
`timescale 1ns/1ps
`default_nettype none
module pcs_stack_mem #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock
    input wire logic hclk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Pointer arithmetic wraps for free only when the depth fills the address range
    if (DEPTH != (1 << AW)) begin : g_bad_depth
        $error("stack depth must equal two to the address width");
    end

    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Forwarding keeps a pop right after a push correct
    always_ff @(posedge hclk) begin
        if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : pcs_stack_mem
`default_nettype wire

/* pcs_core.sv */
// Purpose: Program counter, return stack, paging and indirect addressing of the core
// Assumes: The sequencer raises at most the commands it means; priority settles overlaps
// Notes: Registers over AHB-Lite, zero wait states, always OKAY
//
// Behaviour
// - Program counter holding next fetch address is exactly 13 bits.
// - Counter low byte is a software readable and writable register.
// - High bits 12:8 are not directly readable or writable.
// - Software writes reach the high bits only through the high latch.
// - Return stack is eight entries of 13 bits, outside address spaces.
// - Stack pointer is internal and invisible to software.
// - Calls and interrupt branches push the program counter.
// - Return, return with literal and return from interrupt pop it.
// - Push and pop leave the high latch unchanged.
// - Stack wraps circularly; ninth push overwrites the first, no flag.
// - Call and jump give 11 target bits within a 2K page.
// - Upper two target bits of call and jump come from latch bits 4:3.
// - Every push stores the full 13-bit return address.
// - Indirect port has no storage; it reaches the pointed data register.
// - Pointer at the port itself: read gives zero, write stores nothing.
// - Indirect address is pointer plus an unused bank bit.
`timescale 1ns/1ps
`default_nettype none
module pcs_core
    import pcs_pkg::*;
#(
    parameter logic [12:0] IRQ_VECTOR = PCS_IRQ_VECTOR
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Sequencer commands and fetch address
    input wire pcs_cmd_t cmd,
    output logic [12:0] fetch_addr,
    // Indirect data port
    input wire pcs_ind_req_t ind_req,
    output logic [7:0] ind_rdata,
    output logic [8:0] file_addr,
    output logic file_rd,
    output logic file_wr,
    output logic [7:0] file_wdata,
    input wire logic [7:0] file_rdata
);
    logic [PCS_PC_W-1:0] pc;
    logic [PCS_LATCH_W-1:0] counter_high_latch;
    logic [7:0] file_select_pointer;
    logic [PCS_SP_W-1:0] sp;
    logic [PCS_SP_W-1:0] next_sp;
    logic [PCS_PC_W-1:0] stack_top;
    logic push;
    logic pop;
    logic wr_phase;
    logic [7:0] wr_addr;
    logic low_wr;
    logic latch_wr;
    logic pointer_wr;
    logic addr_ok;
    logic indirect_self;
    // The bank bit exists in the address but these parts never set it
    logic indirect_bank_bit;

    // No wait states: every register answers in the data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && hready && (htrans == PCS_HTRANS_NONSEQ);

    // Address phase captured for the write that follows
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_phase <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_phase <= addr_ok && hwrite && (hsize == PCS_HSIZE_WORD);
            wr_addr <= haddr;
        end
    end

    assign low_wr = wr_phase && (wr_addr == PCS_OFF_LOW_BYTE);
    assign latch_wr = wr_phase && (wr_addr == PCS_OFF_HIGH_LATCH);
    assign pointer_wr = wr_phase && (wr_addr == PCS_OFF_POINTER);

    // Low byte read back; high bits never on the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr)
                PCS_OFF_LOW_BYTE: hrdata <= {24'h00_0000, pc[7:0]};
                PCS_OFF_HIGH_LATCH: hrdata <= {27'h000_0000, counter_high_latch};
                PCS_OFF_POINTER: hrdata <= {24'h00_0000, file_select_pointer};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Latch changes only by a software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_high_latch <= PCS_LATCH_RST;
        end else if (latch_wr) begin
            counter_high_latch <= hwdata[PCS_LATCH_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            file_select_pointer <= PCS_POINTER_RST;
        end else if (pointer_wr) begin
            file_select_pointer <= hwdata[7:0];
        end
    end

    // Push on call or interrupt branch
    assign push = cmd.irq || cmd.call;
    // Pop on any of the three returns unless a push or a jump shares the cycle
    assign pop = !push && !cmd.jump && cmd.ret;

    // Pointer wraps with no overflow or underflow flag
    always_comb begin
        next_sp = sp;
        if (push) begin
            next_sp = sp + 3'h1;
        end else if (pop) begin
            next_sp = sp - 3'h1;
        end
    end

    // Pointer has no bus path at all
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp <= 3'h0;
        end else begin
            sp <= next_sp;
        end
    end

    // Eight by 13 storage; full address stored
    // Read address runs one ahead so a return right after a push finds its entry
    pcs_stack_mem #(
        .WIDTH(PCS_PC_W),
        .DEPTH(PCS_DEPTH),
        .AW(PCS_SP_W)
    ) u_stack (
        .hclk(hclk),
        .we(push),
        .waddr(sp),
        .wdata(pc),
        .raddr(next_sp - 3'h1),
        .rdata(stack_top)
    );

    // Priority: interrupt, call, jump, return, low byte write, fetch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc <= PCS_PC_RST;
        end else if (cmd.irq) begin
            pc <= IRQ_VECTOR;
        end else if (cmd.call || cmd.jump) begin
            // Page from latch, 11 bits from the opcode
            pc <= pcs_page_target(counter_high_latch, cmd.target);
        end else if (cmd.ret) begin
            pc <= stack_top;
        end else if (low_wr) begin
            // High bits only from the latch
            pc <= {counter_high_latch, hwdata[7:0]};
        end else if (cmd.fetch) begin
            pc <= pc + 13'h0001;
        end
    end

    assign fetch_addr = pc;

    // Bank bit unused on these parts
    assign indirect_bank_bit = 1'b0;
    assign file_addr = {indirect_bank_bit, file_select_pointer};
    assign indirect_self = (file_select_pointer == PCS_INDIRECT_SELF);

    // Port forwards to the pointed register, self access is void
    assign file_rd = ind_req.rd && !indirect_self;
    assign file_wr = ind_req.wr && !indirect_self;
    assign file_wdata = ind_req.wdata;
    assign ind_rdata = indirect_self ? 8'h00 : file_rdata;

    // Helper for checks only: entries held, pushes less pops, saturating at depth and at zero
    logic [3:0] fill;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fill <= 4'h0;
        end else if (push && fill != 4'h8) begin
            fill <= fill + 4'h1;
        end else if (pop && fill != 4'h0) begin
            fill <= fill - 4'h1;
        end
    end

    fetch_incr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd.fetch && !cmd.irq && !cmd.call && !cmd.jump && !cmd.ret && !low_wr
        |=> pc == $past(pc) + 13'h0001)
        else $error("fetch did not advance the counter by one");

    jump_page_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !cmd.irq && cmd.jump |=> pc[12:11] == $past(counter_high_latch[4:3])
        && pc[10:0] == $past(cmd.target))
        else $error("jump target not built from latch page and opcode");

    call_return_a: assert property (@(posedge hclk) disable iff (!hresetn)
        push ##1 (!cmd.irq && !cmd.call && !cmd.jump && cmd.ret)
        |=> pc == $past(pc, 2))
        else $error("return did not restore the pushed address");

    irq_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd.irq |=> pc == IRQ_VECTOR && sp == $past(sp) + 3'h1)
        else $error("interrupt branch did not push and vector");

    latch_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (push || pop) && !latch_wr |=> $stable(counter_high_latch))
        else $error("stack operation changed the high latch");

    low_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        low_wr && !cmd.irq && !cmd.call && !cmd.jump && !cmd.ret
        |=> pc == {$past(counter_high_latch), $past(hwdata[7:0])})
        else $error("low byte write did not load high bits from latch");

    stack_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        push && sp == 3'h7 |=> sp == 3'h0)
        else $error("stack pointer did not wrap after eight pushes");

    self_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        indirect_self |-> ind_rdata == 8'h00 && !file_wr && !file_rd)
        else $error("indirect access to the port itself was not void");

    indirect_fwd_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !indirect_self && ind_req.wr |-> file_wr && file_addr[7:0] == file_select_pointer)
        else $error("indirect write not forwarded to pointed register");

    pop_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pop |=> sp == $past(sp) - 3'h1)
        else $error("return did not pop the stack");

    call_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !cmd.irq && cmd.call |=> sp == $past(sp) + 3'h1
        && pc == {$past(counter_high_latch[4:3]), $past(cmd.target)})
        else $error("call did not push and branch to the page target");

    jump_no_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !push && cmd.jump |=> $stable(sp))
        else $error("jump moved the stack pointer");

    low_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite && haddr == PCS_OFF_LOW_BYTE
        |=> hrdata == {24'h00_0000, $past(pc[7:0])})
        else $error("low byte read exposed high bits or wrong data");

    unmapped_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite && haddr != PCS_OFF_LOW_BYTE && haddr != PCS_OFF_HIGH_LATCH
        && haddr != PCS_OFF_POINTER |=> hrdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    latch_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        latch_wr |=> counter_high_latch == $past(hwdata[4:0]))
        else $error("high latch did not take the written value");

    bank_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        file_addr == {1'b0, file_select_pointer})
        else $error("indirect address not pointer with clear bank bit");

    pc_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !cmd.fetch && !cmd.irq && !cmd.call && !cmd.jump && !cmd.ret && !low_wr
        |=> $stable(pc))
        else $error("counter moved without a command");

    ret_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd.ret && push |=> sp == $past(sp) + 3'h1)
        else $error("return beside a push popped the stack");

    // Main scenarios
    call_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        cmd.call ##[1:20] cmd.ret);
    full_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        push && fill == 4'h8);
    self_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        indirect_self && ind_req.rd);
    low_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        low_wr && cmd.fetch);
    irq_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        cmd.irq ##1 cmd.ret);
endmodule : pcs_core
`default_nettype wire

/* pcs_file_model.sv */
// Purpose: Data file that answers the indirect port of the core
// Assumes: Same-cycle read, write taken at the rising edge
// Notes: Idle read lines toggle, so stale data never passes for a match
`timescale 1ns/1ps
`default_nettype none
module pcs_file_model (
    // Clock
    input wire logic hclk,
    // Data file port
    input wire logic [8:0] file_addr,
    input wire logic file_rd,
    input wire logic file_wr,
    input wire logic [7:0] file_wdata,
    output logic [7:0] file_rdata
);
    logic [7:0] mem [256];
    logic flip;
    initial begin
        flip = 1'b0;
        mem[5] = 8'h10;
        mem[6] = 8'h0a;
    end
    always @(posedge hclk) begin
        flip <= ~flip;
        if (file_wr) begin
            mem[file_addr[7:0]] <= file_wdata;
        end
    end
    assign file_rdata = file_rd ? mem[file_addr[7:0]] : ({8{flip}} ^ 8'h3c);
endmodule : pcs_file_model
`default_nettype wire

/* program_counter_stack_tb.sv */
// Purpose: Self-checking bench for the program counter and return stack
// Assumes: Zero-wait AHB-Lite slave, one sequencer command per cycle except the call with return in t_page
// Notes: Each op command and each back-to-back pair is followed by an idle cycle so results are seen settled
`timescale 1ns/1ps
`default_nettype none
module program_counter_stack_tb;
    import pcs_pkg::*;
    localparam logic [4:0] F = 5'h10, C = 5'h08, J = 5'h04, R = 5'h02, I = 5'h01;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = PCS_HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, file_rd, file_wr;
    pcs_cmd_t cmd = '0;
    pcs_ind_req_t ind_req = '0;
    logic [12:0] fetch_addr;
    logic [7:0] ind_rdata, file_wdata, file_rdata;
    logic [8:0] file_addr;
    int n_mismatch = 0;
    int check_count = 0;

    always #2 hclk = ~hclk;

    pcs_core pcs_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cmd(cmd), .fetch_addr(fetch_addr), .ind_req(ind_req), .ind_rdata(ind_rdata),
        .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
        .file_wdata(file_wdata), .file_rdata(file_rdata));
    pcs_file_model pcs_file_model_inst (.hclk(hclk), .file_addr(file_addr),
        .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata),
        .file_rdata(file_rdata));

    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                n_mismatch++;
                report_and_stop;
            end
            @(posedge hclk);
        end
    endtask : rdy

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= PCS_HTRANS_NONSEQ;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        rd = hrdata;
        @(negedge hclk);
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr

    task automatic rr(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(32'(hresp), 32'h0);
    endtask : rr

    task automatic op(input logic [4:0] k, input logic [10:0] t, input logic [12:0] exp);
        @(posedge hclk);
        cmd <= {k, t};
        @(posedge hclk);
        cmd <= '0;
        @(negedge hclk);
        chk(32'(fetch_addr), 32'(exp));
    endtask : op

    // Two commands on consecutive edges, judged after the second
    task automatic pair(input logic [4:0] k1, input logic [4:0] k2, input logic [12:0] exp);
        @(posedge hclk);
        cmd <= {k1, 11'h0aa};
        @(posedge hclk);
        cmd <= {k2, 11'h000};
        @(posedge hclk);
        cmd <= '0;
        @(negedge hclk);
        chk(32'(fetch_addr), 32'(exp));
    endtask : pair

    // Read expects d back; a write expects d on the file write lines
    task automatic ind(input logic r, input logic [7:0] p, input logic [7:0] d);
        @(posedge hclk);
        ind_req <= {r, ~r, d};
        @(negedge hclk);
        chk(32'({file_rd, file_wr, file_addr}), 32'({r && p != 0, !r && p != 0, 1'b0, p}));
        if (r) begin
            chk(32'(ind_rdata), 32'(d));
        end else begin
            chk(32'(file_wdata), 32'(d));
        end
        @(posedge hclk);
        ind_req <= '0;
    endtask : ind

    task automatic t_regs;
        @(negedge hclk);
        chk(32'(fetch_addr), 32'(PCS_PC_RST));
        rr(PCS_OFF_HIGH_LATCH, 32'(PCS_LATCH_RST));
        rr(PCS_OFF_POINTER, 32'(PCS_POINTER_RST));
        wr(PCS_OFF_HIGH_LATCH, 32'hffff_ffff);
        rr(PCS_OFF_HIGH_LATCH, 32'h1f);
        wr(PCS_OFF_LOW_BYTE, 32'h0000_01fe);
        rr(PCS_OFF_LOW_BYTE, 32'hfe);
        wr(8'h0c, 32'h0000_0055);
        rr(8'h0c, 32'h0);
        op(F, 11'h0, 13'h1fff);
        op(F, 11'h0, 13'h0000);
        $display("Register and counter test done");
    endtask : t_regs

    task automatic t_page;
        wr(PCS_OFF_HIGH_LATCH, 32'h1a);
        wr(PCS_OFF_LOW_BYTE, 32'hbc);
        wr(PCS_OFF_HIGH_LATCH, 32'h08);
        op(C, 11'h123, 13'h0923);
        rr(PCS_OFF_HIGH_LATCH, 32'h08);
        op(C | R, 11'h456, 13'h0c56);
        op(J, 11'h7ff, 13'h0fff);
        op(I, 11'h0, PCS_IRQ_VECTOR);
        op(R, 11'h0, 13'h0fff);
        op(R, 11'h0, 13'h0923);
        op(R, 11'h0, 13'h1abc);
        rr(PCS_OFF_HIGH_LATCH, 32'h08);
        $display("Paging and return test done");
    endtask : t_page

    // Nine pushes: the ninth lands on the first slot, so the ninth pop repeats it
    task automatic t_wrap;
        for (int i = 0; i < 9; i++) begin
            op(C, 11'h100 + 11'(i), 13'h0900 + 13'(i));
        end
        for (int k = 0; k < 9; k++) begin
            op(R, 11'h0, 13'h0900 + 13'((15 - k) % 8));
        end
        // Push then pop on the very next edge must hand back the pushed address
        pair(C, R, 13'h0907);
        pair(I, R, 13'h0907);
        $display("Stack wrap test done");
    endtask : t_wrap

    task automatic t_ind;
        wr(PCS_OFF_POINTER, 32'h05);
        rr(PCS_OFF_POINTER, 32'h05);
        ind(1'b1, 8'h05, 8'h10);
        ind(1'b0, 8'h05, 8'hab);
        ind(1'b1, 8'h05, 8'hab);
        wr(PCS_OFF_POINTER, 32'h06);
        ind(1'b1, 8'h06, 8'h0a);
        wr(PCS_OFF_POINTER, 32'h00);
        ind(1'b0, 8'h00, 8'h77);
        ind(1'b1, 8'h00, 8'h00);
        $display("Indirect port test done");
    endtask : t_ind

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_page;
        t_wrap;
        t_ind;
        report_and_stop;
    end
endmodule : program_counter_stack_tb
`default_nettype wire
